// File: rtl/rtc_i2c_pkg.sv
// Shared constants and types for the clock-chip two-wire port and its master.
package rtc_i2c_pkg;
    // ------------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------------
    localparam int CLK_SYS_MHZ = 20;
    localparam int CLK_SYS_PERIOD_NS = 50;
    localparam int SCL_PERIOD_NS = 400;
    // One SCL period is split into four equal quarters by the master.
    localparam int SCL_QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_SYS_PERIOD_NS);

    // ------------------------------------------------------------------
    // Bus timeout
    // ------------------------------------------------------------------
    localparam int SCL_LOW_SAFE_LIMIT_US = 500;
    localparam int SCL_LOW_RESET_THRESHOLD_US = 1000;
    localparam int SCL_LOW_SAFE_CYCLES = SCL_LOW_SAFE_LIMIT_US * CLK_SYS_MHZ;
    localparam int SCL_LOW_RESET_CYCLES =
        SCL_LOW_RESET_THRESHOLD_US * CLK_SYS_MHZ;

    // ------------------------------------------------------------------
    // Addressing and framing
    // ------------------------------------------------------------------
    localparam logic [7:0] DEV_ADDR_WR = 8'hD0;
    localparam logic [7:0] DEV_ADDR_RD = 8'hD1;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] ADDR_CNT_RESET = 8'h00;

    typedef enum logic [1:0] {
        CMD_START,
        CMD_WRITE,
        CMD_READ,
        CMD_STOP
    } cmd_t;
endpackage : rtc_i2c_pkg

// File: rtl/i2c_link_if.sv
// Two-wire link joining the bus master and the clock-chip slave port.
`timescale 1ns/100ps
interface i2c_link_if;
    logic scl_out_mst;
    logic scl_oe_mst;
    logic sda_out_mst;
    logic sda_oe_mst;
    logic sda_out_dev;
    logic sda_oe_dev;
    logic scl;
    logic sda;

    // Wired-AND with pull-ups: a line is low only where some party drives 0.
    assign scl = !(scl_oe_mst && !scl_out_mst);
    assign sda = !((sda_oe_mst && !sda_out_mst) ||
        (sda_oe_dev && !sda_out_dev));

    modport master (
        input scl,
        input sda,
        output scl_out_mst,
        output scl_oe_mst,
        output sda_out_mst,
        output sda_oe_mst
    );

    modport device (
        input scl,
        input sda,
        output sda_out_dev,
        output sda_oe_dev
    );
endinterface : i2c_link_if

// File: rtl/sync2.sv
// Two-stage synchroniser for one bus line; idles high like the pulled-up wire.
`timescale 1ns/100ps
module sync2 (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta;
    logic next_meta;
    logic next_q;

    // The first stage feeds only the second stage.
    always_comb begin
        next_meta = d_i;
        next_q = meta;
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            meta <= 1'h1;
            q_o <= 1'h1;
        end else begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end
endmodule : sync2

// File: rtl/rtc_i2c_slave_port.sv
// Two-wire slave port of the clock chip: addressing, byte transfer, timeout.
`timescale 1ns/100ps
module rtc_i2c_slave_port #(
    parameter int SCL_LOW_RESET_CYCLES = rtc_i2c_pkg::SCL_LOW_RESET_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    i2c_link_if.device link,
    input wire logic osc_run_i,
    input wire logic [7:0] rd_data_i,
    output logic [7:0] rd_addr_o,
    output logic rd_stb_o,
    output logic wr_stb_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o
);
    // ------------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------------
    localparam int TMO_W = $clog2(SCL_LOW_RESET_CYCLES + 1);
    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(SCL_LOW_RESET_CYCLES - 1);
    localparam logic [TMO_W-1:0] TMO_FULL = TMO_W'(SCL_LOW_RESET_CYCLES);

    typedef enum logic [3:0] {
        S_IDLE,
        S_ADDR,
        S_ACK_ADDR,
        S_LOC,
        S_ACK_LOC,
        S_WDATA,
        S_ACK_DATA,
        S_RDATA,
        S_RACK,
        S_IGNORE
    } slv_state_t;
    slv_state_t state;
    slv_state_t next_state;
    logic [3:0] bits;
    logic [3:0] next_bits;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] addr;
    logic [7:0] next_addr;
    logic rw;
    logic next_rw;
    logic drive;
    logic next_drive;
    logic next_rd_stb;
    logic next_wr_stb;
    logic [7:0] next_wr_addr;
    logic [7:0] next_wr_data;
    logic [TMO_W-1:0] tmo_cnt;
    logic [TMO_W-1:0] next_tmo_cnt;
    logic scl_s;
    logic sda_s;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic scl_low_run;
    logic tmo_hit;

    // ------------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------------
    // Both lines come from another clock's world, so each passes two flops.
    sync2 u_sync_scl (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .d_i(link.scl),
        .q_o(scl_s)
    );

    sync2 u_sync_sda (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .d_i(link.sda),
        .q_o(sda_s)
    );

    // Edge and condition decode works on the settled copies only.
    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign start_det = scl_s && scl_q && sda_q && !sda_s;
    assign stop_det = scl_s && scl_q && !sda_q && sda_s;
    assign scl_low_run = !scl_s && osc_run_i;
    assign tmo_hit = scl_low_run && (tmo_cnt == TMO_LAST);

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    // SCL has no driver here at all, so no clock stretching can happen.
    assign link.sda_out_dev = 1'h0;
    assign link.sda_oe_dev = drive;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Timeout beats START, START beats STOP, STOP beats the byte engine.
    always_comb begin
        next_state = state;
        next_bits = bits;
        next_shreg = shreg;
        next_addr = addr;
        next_rw = rw;
        next_drive = drive;
        next_rd_stb = 1'h0;
        next_wr_stb = 1'h0;
        next_wr_addr = wr_addr_o;
        next_wr_data = wr_data_o;
        if (!scl_low_run) begin
            next_tmo_cnt = '0;
        end else if (tmo_cnt == TMO_FULL) begin
            next_tmo_cnt = tmo_cnt;
        end else begin
            next_tmo_cnt = tmo_cnt + TMO_W'(1);
        end
        if (tmo_hit) begin
            next_state = S_IDLE;
            next_drive = 1'h0;
        end else if (start_det) begin
            next_state = S_ADDR;
            next_bits = 4'h0;
            next_drive = 1'h0;
        end else if (stop_det) begin
            next_state = S_IDLE;
            next_drive = 1'h0;
        end else begin
            unique case (state)
                S_IDLE, S_IGNORE: begin
                    next_drive = 1'h0;
                end
                S_ADDR, S_LOC, S_WDATA: begin
                    if (scl_rise && bits != rtc_i2c_pkg::BYTE_BITS) begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_bits = bits + 4'h1;
                    end else if (scl_fall &&
                        bits == rtc_i2c_pkg::BYTE_BITS) begin
                        next_bits = 4'h0;
                        if (state == S_ADDR) begin
                            if (shreg[7:1] ==
                                rtc_i2c_pkg::DEV_ADDR_WR[7:1]) begin
                                next_rw = shreg[0];
                                next_drive = 1'h1;
                                next_state = S_ACK_ADDR;
                            end else begin
                                next_state = S_IGNORE;
                            end
                        end else if (state == S_LOC) begin
                            next_addr = shreg;
                            next_drive = 1'h1;
                            next_state = S_ACK_LOC;
                        end else begin
                            next_wr_stb = 1'h1;
                            next_wr_addr = addr;
                            next_wr_data = shreg;
                            next_addr = addr + 8'h01;
                            next_drive = 1'h1;
                            next_state = S_ACK_DATA;
                        end
                    end
                end
                S_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (rw) begin
                            // Read starts wherever the counter stands.
                            next_shreg = rd_data_i;
                            next_drive = !rd_data_i[7];
                            next_addr = addr + 8'h01;
                            next_rd_stb = 1'h1;
                            next_state = S_RDATA;
                        end else begin
                            next_drive = 1'h0;
                            next_state = S_LOC;
                        end
                    end
                end
                S_ACK_LOC, S_ACK_DATA: begin
                    if (scl_fall) begin
                        next_drive = 1'h0;
                        next_state = S_WDATA;
                    end
                end
                S_RDATA: begin
                    if (scl_rise) begin
                        next_bits = bits + 4'h1;
                    end else if (scl_fall) begin
                        if (bits == rtc_i2c_pkg::BYTE_BITS) begin
                            next_drive = 1'h0;
                            next_state = S_RACK;
                        end else begin
                            next_shreg = {shreg[6:0], 1'h0};
                            next_drive = !shreg[6];
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise && sda_s) begin
                        next_state = S_IGNORE;
                    end else if (scl_fall) begin
                        next_shreg = rd_data_i;
                        next_drive = !rd_data_i[7];
                        next_addr = addr + 8'h01;
                        next_rd_stb = 1'h1;
                        next_bits = 4'h0;
                        next_state = S_RDATA;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state <= S_IDLE;
            bits <= 4'h0;
            shreg <= 8'h00;
            addr <= rtc_i2c_pkg::ADDR_CNT_RESET;
            rw <= 1'h0;
            drive <= 1'h0;
            rd_stb_o <= 1'h0;
            wr_stb_o <= 1'h0;
            wr_addr_o <= 8'h00;
            wr_data_o <= 8'h00;
            tmo_cnt <= '0;
            scl_q <= 1'h1;
            sda_q <= 1'h1;
        end else begin
            state <= next_state;
            bits <= next_bits;
            shreg <= next_shreg;
            addr <= next_addr;
            rw <= next_rw;
            drive <= next_drive;
            rd_stb_o <= next_rd_stb;
            wr_stb_o <= next_wr_stb;
            wr_addr_o <= next_wr_addr;
            wr_data_o <= next_wr_data;
            tmo_cnt <= next_tmo_cnt;
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // The counter itself is the read address; the user returns its data.
    assign rd_addr_o = addr;
endmodule : rtc_i2c_slave_port

// File: rtl/i2c_bus_master.sv
// Command-driven two-wire bus master that makes SCL from the system clock.
`timescale 1ns/100ps
module i2c_bus_master #(
    parameter int QUARTER_CYCLES = rtc_i2c_pkg::SCL_QUARTER_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    i2c_link_if.master link,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire rtc_i2c_pkg::cmd_t cmd_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic cmd_ack_i,
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    output logic rsp_nack_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        M_IDLE,
        M_START,
        M_BIT,
        M_STOP
    } mst_state_t;

    localparam int DIV_W = $clog2(QUARTER_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(QUARTER_CYCLES - 1);

    mst_state_t state;
    mst_state_t next_state;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] next_div;
    logic [1:0] qtr;
    logic [1:0] next_qtr;
    logic [3:0] bitn;
    logic [3:0] next_bitn;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic rd;
    logic next_rd;
    logic ack;
    logic next_ack;
    logic scl_low;
    logic next_scl_low;
    logic sda_low;
    logic next_sda_low;
    logic nack;
    logic next_nack;
    logic next_rsp_valid;
    logic [7:0] next_rsp_data;
    logic next_rsp_nack;
    logic sda_s;
    logic tick;

    sync2 u_sync_sda (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .d_i(link.sda),
        .q_o(sda_s)
    );

    assign tick = (div == DIV_LAST);
    assign cmd_ready_o = (state == M_IDLE);
    // SCL is driven push-pull; the slave never stretches it.
    assign link.scl_out_mst = !scl_low;
    assign link.scl_oe_mst = 1'h1;
    assign link.sda_out_mst = 1'h0;
    assign link.sda_oe_mst = sda_low;

    // ------------------------------------------------------------------
    // Sequencer: each bus step spends four quarters of one SCL period
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_div = (state == M_IDLE || tick) ? '0 : div + DIV_W'(1);
        next_qtr = tick ? qtr + 2'h1 : qtr;
        next_bitn = bitn;
        next_shreg = shreg;
        next_rd = rd;
        next_ack = ack;
        next_scl_low = scl_low;
        next_sda_low = sda_low;
        next_nack = nack;
        next_rsp_valid = 1'h0;
        next_rsp_data = rsp_data_o;
        next_rsp_nack = rsp_nack_o;
        unique case (state)
            M_IDLE: begin
                next_qtr = 2'h0;
                if (cmd_valid_i) begin
                    next_bitn = 4'h0;
                    next_shreg = cmd_data_i;
                    next_rd = (cmd_i == rtc_i2c_pkg::CMD_READ);
                    next_ack = cmd_ack_i;
                    unique case (cmd_i)
                        rtc_i2c_pkg::CMD_START: next_state = M_START;
                        rtc_i2c_pkg::CMD_STOP: next_state = M_STOP;
                        default: next_state = M_BIT;
                    endcase
                end
            end
            M_START: begin
                // Also serves as repeated START from the SCL-low rest.
                if (tick) begin
                    unique case (qtr)
                        2'h0: next_sda_low = 1'h0;
                        2'h1: next_scl_low = 1'h0;
                        2'h2: next_sda_low = 1'h1;
                        2'h3: begin
                            next_scl_low = 1'h1;
                            next_state = M_IDLE;
                        end
                    endcase
                end
            end
            M_BIT: begin
                if (tick) begin
                    unique case (qtr)
                        2'h0: begin
                            if (bitn != rtc_i2c_pkg::BYTE_BITS) begin
                                next_sda_low = !rd && !shreg[7];
                            end else begin
                                next_sda_low = rd && ack;
                            end
                        end
                        2'h1: next_scl_low = 1'h0;
                        2'h2: begin
                            if (bitn != rtc_i2c_pkg::BYTE_BITS) begin
                                next_shreg = {shreg[6:0], sda_s};
                            end else begin
                                next_nack = sda_s;
                            end
                        end
                        2'h3: begin
                            next_scl_low = 1'h1;
                            if (bitn == rtc_i2c_pkg::BYTE_BITS) begin
                                next_rsp_valid = 1'h1;
                                next_rsp_data = shreg;
                                next_rsp_nack = nack;
                                next_state = M_IDLE;
                            end else begin
                                next_bitn = bitn + 4'h1;
                            end
                        end
                    endcase
                end
            end
            M_STOP: begin
                if (tick) begin
                    unique case (qtr)
                        2'h0: next_sda_low = 1'h1;
                        2'h1: next_scl_low = 1'h0;
                        2'h2: next_sda_low = 1'h0;
                        2'h3: next_state = M_IDLE;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state <= M_IDLE;
            div <= '0;
            qtr <= 2'h0;
            bitn <= 4'h0;
            shreg <= 8'h00;
            rd <= 1'h0;
            ack <= 1'h0;
            scl_low <= 1'h0;
            sda_low <= 1'h0;
            nack <= 1'h0;
            rsp_valid_o <= 1'h0;
            rsp_data_o <= 8'h00;
            rsp_nack_o <= 1'h0;
        end else begin
            state <= next_state;
            div <= next_div;
            qtr <= next_qtr;
            bitn <= next_bitn;
            shreg <= next_shreg;
            rd <= next_rd;
            ack <= next_ack;
            scl_low <= next_scl_low;
            sda_low <= next_sda_low;
            nack <= next_nack;
            rsp_valid_o <= next_rsp_valid;
            rsp_data_o <= next_rsp_data;
            rsp_nack_o <= next_rsp_nack;
        end
    end
endmodule : i2c_bus_master

// File: dv/rtc_i2c_props.sv
// Concurrent checks on the two-wire link and the slave's user side.
`timescale 1ns/100ps
module rtc_i2c_props #(
    parameter int LIMIT = 200
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic osc_run_i,
    input wire logic scl,
    input wire logic scl_out_mst,
    input wire logic scl_oe_mst,
    input wire logic sda_out_dev,
    input wire logic sda_oe_dev,
    input wire logic wr_stb_o,
    input wire logic rd_stb_o,
    input wire logic [7:0] wr_addr_o,
    input wire logic [7:0] rd_addr_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    // SCL-low run length while the oscillator runs; saturates to stay small.
    int low_cnt;
    int next_low_cnt;
    always_comb begin
        next_low_cnt = low_cnt + 1;
        if (srst_i || scl || !osc_run_i) begin
            next_low_cnt = 0;
        end else if (low_cnt > LIMIT + 8) begin
            next_low_cnt = low_cnt;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        low_cnt <= next_low_cnt;
    end
    // Sync delay plus release edge give the four cycles of margin.
    property p_timeout; low_cnt > LIMIT + 4 |-> !sda_oe_dev; endproperty
    property p_drain; sda_oe_dev |-> !sda_out_dev; endproperty
    property p_nostretch; scl_oe_mst |-> scl == scl_out_mst; endproperty
    property p_fall; $changed(sda_oe_dev) |-> !scl; endproperty
    property p_hold; $rose(sda_oe_dev) |-> sda_oe_dev [*5]; endproperty
    property p_wstep; wr_stb_o |-> ##[0:2] rd_addr_o == wr_addr_o + 8'h01;
    endproperty
    property p_rstep; rd_stb_o |-> rd_addr_o == $past(rd_addr_o) + 8'h01;
    endproperty
    property p_rload; rd_stb_o |-> !scl; endproperty
    property p_wpulse; wr_stb_o |=> !wr_stb_o; endproperty
    a_timeout: assert property (p_timeout)
        else $error("SDA still driven after SCL timeout.");
    a_drain: assert property (p_drain)
        else $error("Slave drives SDA high.");
    a_nostretch: assert property (p_nostretch)
        else $error("SCL held low against master.");
    a_fall: assert property (p_fall)
        else $error("Slave changed SDA while SCL high.");
    a_hold: assert property (p_hold)
        else $error("Slave low drive too short.");
    a_wstep: assert property (p_wstep)
        else $error("Counter did not step after write.");
    a_rstep: assert property (p_rstep)
        else $error("Counter did not step after read load.");
    a_rload: assert property (p_rload)
        else $error("Read byte loaded while SCL high.");
    a_wpulse: assert property (p_wpulse)
        else $error("Write strobe longer than one cycle.");
    c_write: cover property (wr_stb_o);
    c_read: cover property (rd_stb_o);
    c_timeout: cover property (low_cnt == LIMIT + 5);
endmodule : rtc_i2c_props

// File: dv/tb.sv
// Self-checking bench: bus master and slave port joined over one link.
`timescale 1ns/100ps
module tb;
    localparam int LIMIT = 200;
    logic clk_sys_i = 1'h0;
    logic srst_i = 1'h1;
    logic osc_run_i = 1'h1;
    logic cmd_valid_i = 1'h0;
    rtc_i2c_pkg::cmd_t cmd_i = rtc_i2c_pkg::CMD_STOP;
    logic [7:0] cmd_data_i = 8'h00;
    logic cmd_ack_i = 1'h0;
    logic cmd_ready_o, rsp_valid_o, rsp_nack_o, rd_stb_o, wr_stb_o;
    logic [7:0] rsp_data_o, rd_addr_o, wr_addr_o, wr_data_o;
    logic [7:0] mem [256];
    logic [7:0] bad [3] = '{8'hA0, 8'hD2, 8'h50};
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    i2c_link_if i2c_link_if_inst ();
    i2c_bus_master i2c_bus_master_inst (.clk_sys_i(clk_sys_i),
        .srst_i(srst_i), .link(i2c_link_if_inst), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .cmd_data_i(cmd_data_i),
        .cmd_ack_i(cmd_ack_i), .rsp_valid_o(rsp_valid_o),
        .rsp_data_o(rsp_data_o), .rsp_nack_o(rsp_nack_o));
    rtc_i2c_slave_port #(.SCL_LOW_RESET_CYCLES(LIMIT))
        rtc_i2c_slave_port_inst (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .link(i2c_link_if_inst),
        .osc_run_i(osc_run_i), .rd_data_i(mem[rd_addr_o]),
        .rd_addr_o(rd_addr_o), .rd_stb_o(rd_stb_o), .wr_stb_o(wr_stb_o),
        .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
    rtc_i2c_props #(.LIMIT(LIMIT)) rtc_i2c_props_inst (.clk_sys_i(clk_sys_i),
        .srst_i(srst_i), .osc_run_i(osc_run_i), .scl(i2c_link_if_inst.scl),
        .scl_out_mst(i2c_link_if_inst.scl_out_mst),
        .scl_oe_mst(i2c_link_if_inst.scl_oe_mst),
        .sda_out_dev(i2c_link_if_inst.sda_out_dev),
        .sda_oe_dev(i2c_link_if_inst.sda_oe_dev), .wr_stb_o(wr_stb_o),
        .rd_stb_o(rd_stb_o), .wr_addr_o(wr_addr_o), .rd_addr_o(rd_addr_o));
    // ------------------------------------------------------------------
    // Clock, register space model and hang guard
    // ------------------------------------------------------------------
    always #25 clk_sys_i = ~clk_sys_i;
    // The register space answers at once, as the slave samples it unclocked.
    always @(posedge clk_sys_i) begin
        if (wr_stb_o === 1'h1) mem[wr_addr_o] <= wr_data_o;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Commands are only issued while the master is idle, so one edge takes it.
    task automatic xfer(input rtc_i2c_pkg::cmd_t c, input logic [7:0] d,
        input logic a);
        int n;
        n = 0;
        cmd_i <= c;
        cmd_data_i <= d;
        cmd_ack_i <= a;
        cmd_valid_i <= 1'h1;
        @(posedge clk_sys_i);
        cmd_valid_i <= 1'h0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (cmd_ready_o !== 1'h1 && n < 500);
        // A master that never returns to idle counts against the run.
        if (cmd_ready_o !== 1'h1) begin
            num_errors++;
        end
    endtask : xfer
    task automatic go(input rtc_i2c_pkg::cmd_t c);
        xfer(c, 8'h00, 1'h0);
    endtask : go
    task automatic wr(input logic [7:0] d, input logic nack);
        xfer(rtc_i2c_pkg::CMD_WRITE, d, 1'h0);
        check({7'h00, rsp_valid_o}, 8'h01);
        check({7'h00, rsp_nack_o}, {7'h00, nack});
    endtask : wr
    task automatic rd(input logic a, input logic [7:0] exp);
        xfer(rtc_i2c_pkg::CMD_READ, 8'h00, a);
        check({7'h00, rsp_valid_o}, 8'h01);
        check(rsp_data_o, exp);
    endtask : rd
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = i[7:0];
        repeat (8) @(posedge clk_sys_i);
        srst_i <= 1'h0;
        repeat (8) @(posedge clk_sys_i);
        go(rtc_i2c_pkg::CMD_START);
        wr(8'hD0, 1'h0);
        wr(8'h05, 1'h0);
        wr(8'hAA, 1'h0);
        wr(8'h55, 1'h0);
        go(rtc_i2c_pkg::CMD_STOP);
        check(mem[5], 8'hAA);
        check(mem[6], 8'h55);
        go(rtc_i2c_pkg::CMD_START);
        wr(8'hD0, 1'h0);
        wr(8'h05, 1'h0);
        go(rtc_i2c_pkg::CMD_START);
        wr(8'hD1, 1'h0);
        rd(1'h1, 8'hAA);
        rd(1'h0, 8'h55);
        go(rtc_i2c_pkg::CMD_STOP);
        go(rtc_i2c_pkg::CMD_START);
        wr(8'hD1, 1'h0);
        rd(1'h0, 8'h07);
        go(rtc_i2c_pkg::CMD_STOP);
        check(rd_addr_o, 8'h08);
        foreach (bad[i]) begin
            go(rtc_i2c_pkg::CMD_START);
            wr(bad[i], 1'h1);
            wr(8'h11, 1'h1);
            go(rtc_i2c_pkg::CMD_STOP);
        end
        // With the oscillator stopped a long SCL-low spell is harmless.
        osc_run_i <= 1'h0;
        go(rtc_i2c_pkg::CMD_START);
        wr(8'hD0, 1'h0);
        wr(8'h09, 1'h0);
        repeat (300) @(posedge clk_sys_i);
        wr(8'h77, 1'h0);
        go(rtc_i2c_pkg::CMD_STOP);
        check(mem[9], 8'h77);
        // A timeout in mid-read must drop the slave's low drive.
        osc_run_i <= 1'h1;
        go(rtc_i2c_pkg::CMD_START);
        wr(8'hD0, 1'h0);
        wr(8'h20, 1'h0);
        go(rtc_i2c_pkg::CMD_START);
        wr(8'hD1, 1'h0);
        rd(1'h1, 8'h20);
        repeat (10) @(posedge clk_sys_i);
        check({7'h00, i2c_link_if_inst.sda_oe_dev}, 8'h01);
        repeat (290) @(posedge clk_sys_i);
        check({7'h00, i2c_link_if_inst.sda_oe_dev}, 8'h00);
        wr(8'h33, 1'h1);
        go(rtc_i2c_pkg::CMD_STOP);
        go(rtc_i2c_pkg::CMD_START);
        wr(8'hD0, 1'h0);
        go(rtc_i2c_pkg::CMD_STOP);
        complete_run();
    end
endmodule : tb
